// ===== rbl_top.sv
// relay bank with state feedback, status lamps and axi4-lite registers
`timescale 1ns/1ps
module rbl_top #(
    parameter int RELAYS      = rbl_pkg::RELAYS,
    parameter int CHANNELS    = rbl_pkg::CHANNELS,
    parameter int STRETCH_CYC = rbl_pkg::STRETCH_CYC
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rstn_in,
    // axi4-lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // axi4-lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // axi4-lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    // axi4-lite read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // other network party relay writes
    input  wire logic                ext_wr_in,
    input  wire logic [RELAYS-1:0]   ext_mask_in,
    input  wire logic [RELAYS-1:0]   ext_val_in,
    // relay drive and feedback
    output logic [RELAYS-1:0]        switch_cmd_n_out,
    output logic [RELAYS-1:0]        switch_state_fb_n_out,
    // sensing and network status
    input  wire logic [CHANNELS-1:0] chan_above_in,
    input  wire logic                net_rx_active_in,
    input  wire logic                net_tx_active_in,
    input  wire logic                net_link_in,
    input  wire logic                net_err_in,
    // lamps
    output logic [RELAYS-1:0]        relay_lamp_out,
    output logic [CHANNELS-1:0]      chan_lamp_out,
    output logic                     rx_lamp_out,
    output logic                     tx_lamp_out,
    output logic                     link_lamp_out,
    output logic                     err_lamp_out,
    // interrupt
    output logic                     irq_out
);
    localparam int IW = rbl_pkg::IRQ_W;

    logic [RELAYS-1:0] relay_q;
    logic [IW-1:0]     irq_stat_q;
    logic [IW-1:0]     irq_mask_q;
    logic              aw_held_q;
    logic [7:0]        aw_addr_q;
    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              link_q;
    logic              err_q;
    logic              do_write;
    logic [31:0]       wmerge;
    logic [IW-1:0]     irq_clr;
    logic [IW-1:0]     irq_set;
    logic [RELAYS-1:0] relay_prev_q;
    logic              wr_cmd;
    logic              wr_stat;
    logic              wr_mask;
    logic [RELAYS-1:0] ext_hit;
    logic [RELAYS-1:0] bus_hit;
    logic [31:0]       wclr;
    logic [31:0]       mask_merge;
    logic [31:0]       lamp_word;
    logic [31:0]       rd_word;
    logic              rd_hit;

    // byte-lane merge of write data over an old word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i +: 8] = data[8*i +: 8];
        end
        return r;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        return a == rbl_pkg::ADDR_CMD || a == rbl_pkg::ADDR_STATE ||
               a == rbl_pkg::ADDR_LAMPS || a == rbl_pkg::ADDR_IRQ_STAT ||
               a == rbl_pkg::ADDR_IRQ_MASK;
    endfunction

    // write channels: address and data taken independently, then joined
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            aw_held_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
            aw_held_q <= 1'b1;
        else if (do_write)
            aw_held_q <= 1'b0;
    end

    // address kept until the joined write uses it
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            aw_addr_q <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready)
            aw_addr_q <= s_axi_awaddr;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            w_held_q <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
            w_held_q <= 1'b1;
        else if (do_write)
            w_held_q <= 1'b0;
    end

    // data and strobes kept until the joined write uses them
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            s_axi_bvalid <= 1'b0;
        else if (do_write)
            s_axi_bvalid <= 1'b1;
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // response code decided when the joined write is applied
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            s_axi_bresp <= rbl_pkg::RESP_OKAY;
        else if (do_write)
            s_axi_bresp <= addr_known(aw_addr_q) ? rbl_pkg::RESP_OKAY
                                                 : rbl_pkg::RESP_SLVERR;
    end

    assign wmerge = merge_bytes({{(32-RELAYS){1'b0}}, relay_q}, w_data_q, w_strb_q);

    // one address decode per writable register (command, irq status, irq mask), each driving its own write target
    assign wr_cmd  = do_write && (aw_addr_q == rbl_pkg::ADDR_CMD);
    assign wr_stat = do_write && (aw_addr_q == rbl_pkg::ADDR_IRQ_STAT);
    assign wr_mask = do_write && (aw_addr_q == rbl_pkg::ADDR_IRQ_MASK);

    // clash with a bus command: relays the other party names follow it,
    // the bus keeps every other relay
    assign ext_hit = ext_wr_in ? ext_mask_in : '0;
    assign bus_hit = wr_cmd ? ~ext_hit : '0;

    // one state register per relay, last writer wins
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            relay_q <= rbl_pkg::RESET_CMD[RELAYS-1:0];
        else
        begin
            for (int i = 0; i < RELAYS; i++)
            begin
                if (ext_hit[i])
                    relay_q[i] <= ext_val_in[i];
                else if (bus_hit[i])
                    relay_q[i] <= wmerge[i];
            end
        end
    end

    // relay, feedback and lamp all come from the same register
    assign switch_cmd_n_out      = relay_q;
    assign switch_state_fb_n_out = relay_q;
    assign relay_lamp_out        = relay_q;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            chan_lamp_out <= '0;
        else
            chan_lamp_out <= chan_above_in;
    end

    // link lamp not stretched: link state is long-lived,
    // a short glitch on it is not worth showing
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            link_q <= 1'b0;
        else
            link_q <= net_link_in;
    end
    assign link_lamp_out = link_q;

    // delayed copies for event edge detection; reset to idle pin
    // levels so no false event follows reset
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            err_q <= 1'b0;
        else
            err_q <= net_err_in;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            relay_prev_q <= '0;
        else
            relay_prev_q <= relay_q;
    end

    // short network events would be invisible without stretching
    rbl_stretch #(.CYCLES(STRETCH_CYC)) u_rx (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .event_in (net_rx_active_in),
        .lamp_out (rx_lamp_out)
    );
    rbl_stretch #(.CYCLES(STRETCH_CYC)) u_tx (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .event_in (net_tx_active_in),
        .lamp_out (tx_lamp_out)
    );
    rbl_stretch #(.CYCLES(STRETCH_CYC)) u_err (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .event_in (net_err_in),
        .lamp_out (err_lamp_out)
    );

    // sticky events: relay change, error rise, link change
    always_comb
    begin
        irq_set = '0;
        irq_set[rbl_pkg::IRQ_CHG_LSB +: RELAYS] = relay_q ^ relay_prev_q;
        irq_set[rbl_pkg::IRQ_ERR_BIT]  = net_err_in && !err_q;
        irq_set[rbl_pkg::IRQ_LINK_BIT] = net_link_in ^ link_q;
    end

    // write one to clear, only in enabled byte lanes
    assign wclr       = merge_bytes(32'h0000_0000, w_data_q, w_strb_q);
    assign irq_clr    = wr_stat ? wclr[IW-1:0] : '0;
    assign mask_merge = merge_bytes({{(32-IW){1'b0}}, irq_mask_q}, w_data_q, w_strb_q);

    // set wins over clear in the same cycle
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            irq_stat_q <= '0;
        else
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            irq_mask_q <= rbl_pkg::RESET_MASK[IW-1:0];
        else if (wr_mask)
            irq_mask_q <= mask_merge[IW-1:0];
    end

    assign irq_out = |(irq_stat_q & irq_mask_q);

    // lamp snapshot: channels in byte one, network lamps in the low nibble
    always_comb
    begin
        lamp_word                = 32'h0000_0000;
        lamp_word[8 +: CHANNELS] = chan_lamp_out;
        lamp_word[3:0]           = {err_lamp_out, link_lamp_out, tx_lamp_out, rx_lamp_out};
    end

    // unmapped addresses read zero with an error response
    assign rd_hit = addr_known(s_axi_araddr);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            rbl_pkg::ADDR_CMD,
            rbl_pkg::ADDR_STATE:    rd_word = {{(32-RELAYS){1'b0}}, relay_q};
            rbl_pkg::ADDR_LAMPS:    rd_word = lamp_word;
            rbl_pkg::ADDR_IRQ_STAT: rd_word = {{(32-IW){1'b0}}, irq_stat_q};
            rbl_pkg::ADDR_IRQ_MASK: rd_word = {{(32-IW){1'b0}}, irq_mask_q};
            default:                rd_word = 32'h0000_0000;
        endcase
    end

    // read channel: one read at a time, answer one cycle after address
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            s_axi_rvalid <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            s_axi_rvalid <= 1'b1;
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // data captured with the address, held while rvalid stands
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rbl_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? rbl_pkg::RESP_OKAY : rbl_pkg::RESP_SLVERR;
        end
    end
endmodule

// ===== rbl_pkg.sv
// package of constants for the relay bank and status lamp block
package rbl_pkg;
    localparam int          RELAYS        = 8;
    localparam int          CHANNELS      = 8;
    localparam int          CLK_HZ        = 200_000_000;
    // lamp stretch time in microseconds
    localparam int          STRETCH_US    = 50_000;
    localparam int          STRETCH_CYC   = (CLK_HZ / 1_000_000) * STRETCH_US;
    localparam int          STRETCH_W     = $clog2(STRETCH_CYC + 1);
    // axi register map
    localparam logic [7:0]  ADDR_CMD      = 8'h00;
    localparam logic [7:0]  ADDR_STATE    = 8'h04;
    localparam logic [7:0]  ADDR_LAMPS    = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;
    localparam logic [31:0] RESET_CMD     = 32'h0000_0000;
    localparam logic [31:0] RESET_MASK    = 32'h0000_0000;
    // irq status layout
    localparam int          IRQ_CHG_LSB   = 0;
    localparam int          IRQ_ERR_BIT   = 8;
    localparam int          IRQ_LINK_BIT  = 9;
    localparam int          IRQ_W         = 10;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== rbl_stretch.sv
// pulse stretcher for one activity lamp
`timescale 1ns/1ps
module rbl_stretch #(
    parameter int CYCLES = rbl_pkg::STRETCH_CYC
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // event and lamp
    input  wire logic event_in,
    output logic      lamp_out
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    // retrigger on every event so a burst keeps the lamp lit
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            cnt_q <= '0;
        else if (event_in)
            cnt_q <= W'(CYCLES);
        else if (cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            lamp_out <= 1'b0;
        else
            lamp_out <= event_in || (cnt_q > W'(1));
    end
endmodule

// ===== rbl_top_properties.sv
// assertion checker for the relay bank and lamp block
`timescale 1ns/1ps
module rbl_props #(
    parameter int RELAYS      = 8,
    parameter int CHANNELS    = 8,
    parameter int STRETCH_CYC = 16
) (
    // clock and reset
    input wire logic                clk_in,
    input wire logic                rstn_in,
    // relay writes and state
    input wire logic                ext_wr_in,
    input wire logic [RELAYS-1:0]   ext_mask_in,
    input wire logic [RELAYS-1:0]   ext_val_in,
    input wire logic [RELAYS-1:0]   switch_cmd_n_out,
    input wire logic [RELAYS-1:0]   switch_state_fb_n_out,
    input wire logic [RELAYS-1:0]   relay_lamp_out,
    // sensing, network and lamps
    input wire logic [CHANNELS-1:0] chan_above_in,
    input wire logic [CHANNELS-1:0] chan_lamp_out,
    input wire logic                net_rx_active_in,
    input wire logic                net_tx_active_in,
    input wire logic                net_link_in,
    input wire logic                net_err_in,
    input wire logic                rx_lamp_out,
    input wire logic                tx_lamp_out,
    input wire logic                link_lamp_out,
    input wire logic                err_lamp_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // short events must stay visible for several cycles
    sequence lit_s(sig);
        sig [*4];
    endsequence

    fb_tracks_a: assert property (switch_state_fb_n_out == switch_cmd_n_out)
        else $error("feedback differs from relay drive");
    lamp_tracks_a: assert property (relay_lamp_out == switch_cmd_n_out)
        else $error("relay lamp differs from relay drive");
    ext_write_a: assert property (ext_wr_in |=>
        ((switch_cmd_n_out ^ $past(ext_val_in)) & $past(ext_mask_in)) == '0)
        else $error("other party write not applied");
    chan_lamp_a: assert property ($past(rstn_in) |-> chan_lamp_out == $past(chan_above_in))
        else $error("channel lamp wrong");
    link_lamp_a: assert property ($past(rstn_in) |-> link_lamp_out == $past(net_link_in))
        else $error("link lamp wrong");
    rx_stretch_a: assert property (net_rx_active_in |=> lit_s(rx_lamp_out))
        else $error("receive lamp not lit");
    tx_stretch_a: assert property (net_tx_active_in |=> lit_s(tx_lamp_out))
        else $error("transmit lamp not lit");
    err_stretch_a: assert property (net_err_in |=> lit_s(err_lamp_out))
        else $error("error lamp not lit");
endmodule

bind rbl_top rbl_props #(.RELAYS(RELAYS), .CHANNELS(CHANNELS), .STRETCH_CYC(STRETCH_CYC))
    u_rbl_props (.clk_in, .rstn_in, .ext_wr_in, .ext_mask_in, .ext_val_in, .switch_cmd_n_out,
    .switch_state_fb_n_out, .relay_lamp_out, .chan_above_in, .chan_lamp_out, .net_rx_active_in,
    .net_tx_active_in, .net_link_in, .net_err_in, .rx_lamp_out, .tx_lamp_out, .link_lamp_out,
    .err_lamp_out);

// ===== rbl_ext_party.sv
// model of the other network party that writes relays directly
`timescale 1ns/1ps
module rbl_ext_party (
    // clock
    input  wire logic clk_in,
    // relay write strobe
    output logic       wr_out,
    output logic [7:0] mask_out,
    output logic [7:0] val_out
);
    initial
    begin
        wr_out = 1'b0;
        mask_out = 8'h00;
        val_out = 8'h00;
    end
    // qualifiers scrambled after the strobe so stale values never pass
    task automatic send(input logic [7:0] m, input logic [7:0] v);
        @(posedge clk_in);
        wr_out <= 1'b1;
        mask_out <= m;
        val_out <= v;
        @(posedge clk_in);
        wr_out <= 1'b0;
        mask_out <= ~m;
        val_out <= ~v;
        #1;
    endtask
endmodule

// ===== rbl_top_tb.sv
// self-checking testbench for the relay bank and lamp block
`timescale 1ns/1ps
module rbl_top_tb;
    localparam int ST = 16;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        ext_wr_in, net_link_in, irq_out, rx_lamp_out, tx_lamp_out;
    logic        link_lamp_out, err_lamp_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  ev;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_mask_in, ext_val_in, chan_above_in;
    logic [7:0]  switch_cmd_n_out, switch_state_fb_n_out, relay_lamp_out, chan_lamp_out;
    logic [7:0]  pat [2];
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          n_fail, cmp_count;

    rbl_top #(.STRETCH_CYC(ST)) u_rbl_top (
        .clk_in, .rstn_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .ext_wr_in, .ext_mask_in, .ext_val_in, .switch_cmd_n_out,
        .switch_state_fb_n_out, .chan_above_in, .net_rx_active_in(ev[0]),
        .net_tx_active_in(ev[1]), .net_link_in, .net_err_in(ev[2]), .relay_lamp_out,
        .chan_lamp_out, .rx_lamp_out, .tx_lamp_out, .link_lamp_out, .err_lamp_out, .irq_out);
    rbl_ext_party u_rbl_ext_party (.clk_in, .wr_out(ext_wr_in), .mask_out(ext_mask_in),
        .val_out(ext_val_in));

    always #2.5 clk_in = ~clk_in;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_in);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        #1;
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_in);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        #1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // generous bound: whole run is under two hundred cycles
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_fail++;
        test_done();
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {chan_above_in, net_link_in, ev} = 12'h000;
        pat = '{8'hA5, 8'h5A};
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        axr(rbl_pkg::ADDR_CMD, rbl_pkg::RESET_CMD, rbl_pkg::RESP_OKAY);
        axr(rbl_pkg::ADDR_IRQ_MASK, rbl_pkg::RESET_MASK, rbl_pkg::RESP_OKAY);
        chk("relays", 32'h0, {24'h0, switch_cmd_n_out});
        $display("test reset done");
        for (int i = 0; i < 2; i++)
        begin
            axw(rbl_pkg::ADDR_CMD, {24'h0, pat[i]}, rbl_pkg::RESP_OKAY);
            chk("drive", {24'h0, pat[i]}, {24'h0, switch_cmd_n_out});
            chk("feedback", {24'h0, pat[i]}, {24'h0, switch_state_fb_n_out});
            chk("relay lamp", {24'h0, pat[i]}, {24'h0, relay_lamp_out});
            axr(rbl_pkg::ADDR_STATE, {24'h0, pat[i]}, rbl_pkg::RESP_OKAY);
        end
        axw(rbl_pkg::ADDR_STATE, 32'h0000_00FF, rbl_pkg::RESP_OKAY);
        axr(rbl_pkg::ADDR_STATE, 32'h0000_005A, rbl_pkg::RESP_OKAY);
        axw(8'h40, 32'h0000_0001, rbl_pkg::RESP_SLVERR);
        axr(8'h40, 32'h0, rbl_pkg::RESP_SLVERR);
        $display("test bus command done");
        axw(rbl_pkg::ADDR_IRQ_STAT, 32'hFFFF_FFFF, rbl_pkg::RESP_OKAY);
        axw(rbl_pkg::ADDR_IRQ_MASK, 32'h0000_00FF, rbl_pkg::RESP_OKAY);
        axr(rbl_pkg::ADDR_IRQ_MASK, 32'h0000_00FF, rbl_pkg::RESP_OKAY);
        chk("irq idle", 32'h0, {31'h0, irq_out});
        u_rbl_ext_party.send(8'hF0, 8'h30);
        chk("ext drive", 32'h3A, {24'h0, switch_cmd_n_out});
        chk("ext feedback", 32'h3A, {24'h0, switch_state_fb_n_out});
        axr(rbl_pkg::ADDR_STATE, 32'h0000_003A, rbl_pkg::RESP_OKAY);
        chk("irq set", 32'h1, {31'h0, irq_out});
        axr(rbl_pkg::ADDR_IRQ_STAT, 32'h0000_0060, rbl_pkg::RESP_OKAY);
        axw(rbl_pkg::ADDR_IRQ_STAT, 32'h0000_0020, rbl_pkg::RESP_OKAY);
        chk("irq partial", 32'h1, {31'h0, irq_out});
        axw(rbl_pkg::ADDR_IRQ_STAT, 32'h0000_0040, rbl_pkg::RESP_OKAY);
        chk("irq clear", 32'h0, {31'h0, irq_out});
        axw(rbl_pkg::ADDR_IRQ_MASK, 32'h0, rbl_pkg::RESP_OKAY);
        u_rbl_ext_party.send(8'h01, 8'h01);
        axr(rbl_pkg::ADDR_IRQ_STAT, 32'h0000_0001, rbl_pkg::RESP_OKAY);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        $display("test other party done");
        @(posedge clk_in);
        chan_above_in <= 8'h96;
        net_link_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("chan lamp", 32'h96, {24'h0, chan_lamp_out});
        chk("link lamp", 32'h1, {31'h0, link_lamp_out});
        axr(rbl_pkg::ADDR_LAMPS, 32'h0000_9604, rbl_pkg::RESP_OKAY);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_in);
            ev <= 3'h1 << i;
            @(posedge clk_in);
            ev <= 3'h0;
            #1;
            chk("act lamp", 32'h1 << i, {29'h0, err_lamp_out, tx_lamp_out, rx_lamp_out});
            repeat (ST - 1) @(posedge clk_in);
            #1;
            chk("held lamp", 32'h1 << i, {29'h0, err_lamp_out, tx_lamp_out, rx_lamp_out});
            repeat (1) @(posedge clk_in);
            #1;
            chk("dark lamp", 32'h0, {29'h0, err_lamp_out, tx_lamp_out, rx_lamp_out});
        end
        @(posedge clk_in);
        net_link_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk("link off", 32'h0, {31'h0, link_lamp_out});
        axr(rbl_pkg::ADDR_IRQ_STAT, 32'h0000_0301, rbl_pkg::RESP_OKAY);
        $display("test lamps done");
        test_done();
    end
endmodule
